/* File: design/srlc_defs.vh */
/*
 Constants for the strap, reset and LED configuration block.
 Assumes a 100 MHz system clock and AXI4-Lite register access.
*/
`ifndef SRLC_DEFS_VH
`define SRLC_DEFS_VH
`define SRLC_CLK_HZ 100000000
`define SRLC_RESET_MS 1
`define SRLC_RESET_CYC ((`SRLC_CLK_HZ / 1000) * `SRLC_RESET_MS + 1)
`define SRLC_BLINK_HZ 20
`define SRLC_BLINK_HALF_CYC (`SRLC_CLK_HZ / (2 * `SRLC_BLINK_HZ))
`define SRLC_OFS_BASIC 8'h00
`define SRLC_OFS_CODING 8'h04
`define SRLC_OFS_STRAP 8'h08
`define SRLC_OFS_STATUS 8'h0c
`define SRLC_BIT_LOOPBACK 14
`define SRLC_BIT_AUTONEG 12
`define SRLC_BIT_MLT3_BYP 1
`define SRLC_BIT_STRAP_DUPCOL 4
`define SRLC_BIT_STRAP_SPEED 3
`define SRLC_BIT_ADV_LO 0
`define SRLC_RESP_OKAY 2'b00
`define SRLC_RESP_SLVERR 2'b10
`endif

/* File: design/srlc_top.v */
/*
 Strap latching, reset sequencing and LED drive of a 10/100 transceiver,
 with AXI4-Lite access to the control, coding, strap and status words.
 Assumes pins and the management clock are asynchronous to I_CLK_SYS and
 that the board drives the LED pins with pull resistors while we release.
*/
// The AXI4-Lite interface to the registers and the register addresses were chosen for this implementation.
// Notes on behaviour
// - In half duplex a collision blinks the duplex/collision LED at 20 Hz.
// - At reset the duplex/collision LED pin level is stored in strap bit 4.
// - The 100 Mb/s LED is lit steadily while the link speed is 100 Mb/s.
// - At reset the 100 Mb/s LED pin level is stored in strap bit 3.
// - With autonegotiation on, straps A and B select the advertised modes.
// - With autonegotiation off, strap A high bypasses MLT-3 and sets bit 1.
// - With autonegotiation off, strap B high sets loopback bit 14.
// - The device resets itself at power-up whatever the reset input does.
// - Reset completes only after over 1 ms and one management clock edge.
// - Reset-done is low while reset is pending and high once usable.
`timescale 1ns/1ns
`default_nettype none
`include "srlc_defs.vh"
module srlc_top #(
   parameter RESET_CYC = `SRLC_RESET_CYC,
   parameter BLINK_HALF_CYC = `SRLC_BLINK_HALF_CYC
) (
   input wire I_CLK_SYS,
   input wire I_RST,
   input wire I_RESET_N,
   input wire I_MDC,
   input wire I_STRAP_CONFIG_A,
   input wire I_STRAP_CONFIG_B,
   input wire I_AUTONEG_STRAP,
   input wire I_INTERFACE_SELECT_STRAP,
   input wire I_LINK_UP,
   input wire I_SPEED_100,
   input wire I_FULL_DUPLEX,
   input wire I_COLLISION,
   input wire I_LED_DUPCOL,
   input wire I_LED_SPEED,
   output reg O_LED_DUPCOL,
   output reg O_LED_DUPCOL_OE,
   output reg O_LED_SPEED,
   output reg O_LED_SPEED_OE,
   output reg O_RESET_DONE,
   output reg O_MLT3_BYPASS,
   output reg O_LOOPBACK,
   output reg O_AUTONEG_EN,
   output reg [1:0] O_ADVERTISE_SEL,
   output reg O_REDUCED_IF,
   input wire [31:0] S_AXI_AWADDR,
   input wire S_AXI_AWVALID,
   output reg S_AXI_AWREADY,
   input wire [31:0] S_AXI_WDATA,
   input wire [3:0] S_AXI_WSTRB,
   input wire S_AXI_WVALID,
   output reg S_AXI_WREADY,
   output reg [1:0] S_AXI_BRESP,
   output reg S_AXI_BVALID,
   input wire S_AXI_BREADY,
   input wire [31:0] S_AXI_ARADDR,
   input wire S_AXI_ARVALID,
   output reg S_AXI_ARREADY,
   output reg [31:0] S_AXI_RDATA,
   output reg [1:0] S_AXI_RRESP,
   output reg S_AXI_RVALID,
   input wire S_AXI_RREADY
);
   localparam NSYNC = 9;
   localparam ST_RESET = 2'b00;
   localparam ST_WAIT_MDC = 2'b01;
   localparam ST_LATCH = 2'b10;
   localparam ST_READY = 2'b11;

   function known_offset;
      input [7:0] ofs;
      begin
         known_offset = (ofs == `SRLC_OFS_BASIC) ||
            (ofs == `SRLC_OFS_CODING) || (ofs == `SRLC_OFS_STRAP) ||
            (ofs == `SRLC_OFS_STATUS);
      end
   endfunction

   // Three-stage synchronisers; a change counts when stages 2 and 3 agree.
   wire [NSYNC-1:0] pin_raw;
   reg [NSYNC-1:0] s1_q;
   reg [NSYNC-1:0] s2_q;
   reg [NSYNC-1:0] s3_q;
   reg [NSYNC-1:0] pin_q;
   assign pin_raw = {I_RESET_N, I_MDC, I_STRAP_CONFIG_A, I_STRAP_CONFIG_B,
      I_AUTONEG_STRAP, I_INTERFACE_SELECT_STRAP, I_LED_DUPCOL, I_LED_SPEED,
      I_COLLISION};
   genvar g;
   generate
      for (g = 0; g < NSYNC; g = g + 1) begin : g_sync
         always @(posedge I_CLK_SYS or posedge I_RST) begin
            if (I_RST) begin
               s1_q[g] <= 1'b0;
               s2_q[g] <= 1'b0;
               s3_q[g] <= 1'b0;
               pin_q[g] <= 1'b0;
            end else begin
               s1_q[g] <= pin_raw[g];
               s2_q[g] <= s1_q[g];
               s3_q[g] <= s2_q[g];
               if (s2_q[g] == s3_q[g]) begin
                  pin_q[g] <= s3_q[g];
               end
            end
         end
      end
   endgenerate
   wire rst_n_s = pin_q[8];
   wire mdc_s = pin_q[7];
   wire cfg_a_s = pin_q[6];
   wire cfg_b_s = pin_q[5];
   wire an_s = pin_q[4];
   wire ifsel_s = pin_q[3];
   wire led_dupcol_s = pin_q[2];
   wire led_speed_s = pin_q[1];
   wire col_s = pin_q[0];

   // Reset sequencer. I_RST acts as power-up, which needs no reset pin.
   reg [1:0] state_q;
   reg [31:0] cnt_q;
   reg mdc_prev_q;
   reg mdc_seen_q;
   reg [31:0] low_cnt_q;
   reg [15:0] basic_q;
   reg [15:0] coding_q;
   reg [15:0] strap_q;
   // A reset pin pulse shorter than the hold time is ignored; one held
   // long enough restarts the sequence, which then needs a new MDC edge.
   wire mdc_edge = mdc_s != mdc_prev_q;
   wire ext_reset = low_cnt_q >= RESET_CYC - 1;
   always @(posedge I_CLK_SYS or posedge I_RST) begin
      if (I_RST) begin
         state_q <= ST_RESET;
         cnt_q <= 32'h0;
         mdc_prev_q <= 1'b0;
         mdc_seen_q <= 1'b0;
         low_cnt_q <= 32'h0;
      end else begin
         // The MDC edge detector tracks the pin through ST_RESET, so a clock
         // that rests high at power-up does not count as the transition.
         mdc_prev_q <= mdc_s;
         if (!rst_n_s) begin
            if (!ext_reset) begin
               low_cnt_q <= low_cnt_q + 32'h1;
            end
         end else begin
            low_cnt_q <= 32'h0;
         end
         if (!rst_n_s && ext_reset) begin
            state_q <= ST_RESET;
            cnt_q <= 32'h0;
            mdc_seen_q <= 1'b0;
         end else begin
            case (state_q)
               ST_RESET: begin
                  if (rst_n_s) begin
                     state_q <= ST_WAIT_MDC;
                  end
               end
               ST_WAIT_MDC: begin
                  if (mdc_edge) begin
                     mdc_seen_q <= 1'b1;
                  end
                  if (cnt_q < RESET_CYC) begin
                     cnt_q <= cnt_q + 32'h1;
                  end
                  if (cnt_q >= RESET_CYC && (mdc_seen_q || mdc_edge)) begin
                     state_q <= ST_LATCH;
                  end
               end
               ST_LATCH: begin
                  state_q <= ST_READY;
               end
               ST_READY: begin
                  state_q <= ST_READY;
               end
               default: begin
                  state_q <= ST_RESET;
               end
            endcase
         end
      end
   end

   // Strap capture and register file, plus the AXI4-Lite slave.
   reg aw_q;
   reg w_q;
   reg [7:0] awaddr_q;
   reg [31:0] wdata_q;
   reg [3:0] wstrb_q;
   reg [15:0] wr_val;
   reg [15:0] cur_val;
   // Lanes 0 and 1 merge into the current word; the upper lanes have no
   // storage behind them and are dropped.
   always @* begin
      case (awaddr_q)
         `SRLC_OFS_BASIC: cur_val = basic_q;
         `SRLC_OFS_CODING: cur_val = coding_q;
         default: cur_val = 16'h0;
      endcase
      wr_val = cur_val;
      if (wstrb_q[0]) begin
         wr_val[7:0] = wdata_q[7:0];
      end
      if (wstrb_q[1]) begin
         wr_val[15:8] = wdata_q[15:8];
      end
   end
   // Writes to known offsets that finish before READY are answered OKAY and dropped, so
   // software cannot disturb words whose straps are not latched yet.
   wire ready = state_q == ST_READY;
   always @(posedge I_CLK_SYS or posedge I_RST) begin
      if (I_RST) begin
         basic_q <= 16'h0;
         coding_q <= 16'h0;
         strap_q <= 16'h0;
         aw_q <= 1'b0;
         w_q <= 1'b0;
         awaddr_q <= 8'h0;
         wdata_q <= 32'h0;
         wstrb_q <= 4'h0;
         S_AXI_AWREADY <= 1'b0;
         S_AXI_WREADY <= 1'b0;
         S_AXI_BVALID <= 1'b0;
         S_AXI_BRESP <= `SRLC_RESP_OKAY;
         S_AXI_ARREADY <= 1'b0;
         S_AXI_RVALID <= 1'b0;
         S_AXI_RDATA <= 32'h0;
         S_AXI_RRESP <= `SRLC_RESP_OKAY;
      end else begin
         if (state_q == ST_LATCH) begin
            strap_q <= 16'h0;
            strap_q[`SRLC_BIT_STRAP_DUPCOL] <= led_dupcol_s;
            strap_q[`SRLC_BIT_STRAP_SPEED] <= led_speed_s;
            basic_q <= 16'h0;
            basic_q[`SRLC_BIT_AUTONEG] <= an_s;
            coding_q <= 16'h0;
            if (!an_s) begin
               basic_q[`SRLC_BIT_LOOPBACK] <= cfg_b_s;
               coding_q[`SRLC_BIT_MLT3_BYP] <= cfg_a_s;
            end
         end
         // Each ready pulses once per request and stays low while an
         // accepted word waits for its answer: one write at a time.
         S_AXI_AWREADY <= !aw_q && !S_AXI_AWREADY && S_AXI_AWVALID;
         S_AXI_WREADY <= !w_q && !S_AXI_WREADY && S_AXI_WVALID;
         if (S_AXI_AWREADY && S_AXI_AWVALID) begin
            aw_q <= 1'b1;
            awaddr_q <= S_AXI_AWADDR[7:0];
         end
         if (S_AXI_WREADY && S_AXI_WVALID) begin
            w_q <= 1'b1;
            wdata_q <= S_AXI_WDATA;
            wstrb_q <= S_AXI_WSTRB;
         end
         if (aw_q && w_q && !S_AXI_BVALID) begin
            S_AXI_BVALID <= 1'b1;
            S_AXI_BRESP <= known_offset(awaddr_q) ? `SRLC_RESP_OKAY :
               `SRLC_RESP_SLVERR;
            if (ready && awaddr_q == `SRLC_OFS_BASIC) begin
               basic_q <= wr_val;
            end
            if (ready && awaddr_q == `SRLC_OFS_CODING) begin
               coding_q <= wr_val;
            end
         end
         if (S_AXI_BVALID && S_AXI_BREADY) begin
            S_AXI_BVALID <= 1'b0;
            aw_q <= 1'b0;
            w_q <= 1'b0;
         end
         // Read data is registered with its response; the status word
         // packs the live A, B and interface straps, the link inputs and the sequencer state.
         S_AXI_ARREADY <= !S_AXI_ARREADY && !S_AXI_RVALID && S_AXI_ARVALID;
         if (S_AXI_ARREADY && S_AXI_ARVALID) begin
            S_AXI_RVALID <= 1'b1;
            S_AXI_RRESP <= known_offset(S_AXI_ARADDR[7:0]) ?
               `SRLC_RESP_OKAY : `SRLC_RESP_SLVERR;
            case (S_AXI_ARADDR[7:0])
               `SRLC_OFS_BASIC: S_AXI_RDATA <= {16'h0, basic_q};
               `SRLC_OFS_CODING: S_AXI_RDATA <= {16'h0, coding_q};
               `SRLC_OFS_STRAP: S_AXI_RDATA <= {16'h0, strap_q};
               `SRLC_OFS_STATUS: S_AXI_RDATA <= {24'h0, cfg_a_s, cfg_b_s,
                  ifsel_s, I_FULL_DUPLEX, I_SPEED_100, I_LINK_UP,
                  state_q};
               default: S_AXI_RDATA <= 32'h0;
            endcase
         end else if (S_AXI_RVALID && S_AXI_RREADY) begin
            S_AXI_RVALID <= 1'b0;
         end
      end
   end

   // Collision blink; LED pins are released until straps are latched.
   reg [31:0] blink_cnt_q;
   reg blink_q;
   wire blink_on = !I_FULL_DUPLEX && col_s;
   always @(posedge I_CLK_SYS or posedge I_RST) begin
      if (I_RST) begin
         blink_cnt_q <= 32'h0;
         blink_q <= 1'b0;
         O_LED_DUPCOL <= 1'b0;
         O_LED_DUPCOL_OE <= 1'b0;
         O_LED_SPEED <= 1'b0;
         O_LED_SPEED_OE <= 1'b0;
         O_RESET_DONE <= 1'b0;
         O_MLT3_BYPASS <= 1'b0;
         O_LOOPBACK <= 1'b0;
         O_AUTONEG_EN <= 1'b0;
         O_ADVERTISE_SEL <= 2'b00;
         O_REDUCED_IF <= 1'b0;
      end else begin
         // The blink counter restarts with each collision, so the first
         // flash comes one half period after the collision is seen.
         if (!blink_on) begin
            blink_cnt_q <= 32'h0;
            blink_q <= 1'b0;
         end else if (blink_cnt_q >= BLINK_HALF_CYC - 1) begin
            blink_cnt_q <= 32'h0;
            blink_q <= !blink_q;
         end else begin
            blink_cnt_q <= blink_cnt_q + 32'h1;
         end
         // LED pins stay released until READY, so the strap resistors set
         // the levels that ST_LATCH takes in.
         O_LED_DUPCOL_OE <= ready;
         O_LED_SPEED_OE <= ready;
         O_LED_DUPCOL <= I_FULL_DUPLEX || (blink_on && blink_q);
         O_LED_SPEED <= I_LINK_UP && I_SPEED_100;
         O_RESET_DONE <= ready;
         O_MLT3_BYPASS <= coding_q[`SRLC_BIT_MLT3_BYP];
         O_LOOPBACK <= basic_q[`SRLC_BIT_LOOPBACK];
         O_AUTONEG_EN <= basic_q[`SRLC_BIT_AUTONEG];
         O_ADVERTISE_SEL <= basic_q[`SRLC_BIT_AUTONEG] ?
            {cfg_b_s, cfg_a_s} : 2'b00;
         O_REDUCED_IF <= ifsel_s;
      end
   end
endmodule // srlc_top
`default_nettype wire

/* File: testbench/srlc_sva.sv */
/* Checker for srlc_top: reset sequence, LED drive and advertisement.
 Assumes strap changes reach the outputs within a few cycles. */
`timescale 1ns/1ns
`default_nettype none
module srlc_sva #(
   parameter RESET_CYC = 20
) (
   input wire logic I_CLK_SYS,
   input wire logic I_RST,
   input wire logic I_RESET_N,
   input wire logic I_MDC,
   input wire logic I_STRAP_CONFIG_A,
   input wire logic I_STRAP_CONFIG_B,
   input wire logic I_LINK_UP,
   input wire logic I_SPEED_100,
   input wire logic I_FULL_DUPLEX,
   input wire logic I_COLLISION,
   input wire logic O_LED_DUPCOL,
   input wire logic O_LED_SPEED,
   input wire logic O_RESET_DONE,
   input wire logic O_AUTONEG_EN,
   input wire logic [1:0] O_ADVERTISE_SEL
);
   logic [31:0] cyc_q;
   logic mdc_q, seen_q;
   logic [1:0] strap_prev_q;
   logic [3:0] steady_q;
   default clocking @(posedge I_CLK_SYS);
   endclocking
   default disable iff (I_RST);
   // Cycles since the reset pin rose, and whether MDC has moved since.
   always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
      if (I_RST) begin
         cyc_q <= 32'h0;
         mdc_q <= 1'b0;
         seen_q <= 1'b0;
         strap_prev_q <= 2'b00;
         steady_q <= 4'h0;
      end else begin
         // Cycles since the straps last moved, saturating.
         strap_prev_q <= {I_STRAP_CONFIG_B, I_STRAP_CONFIG_A};
         steady_q <= ({I_STRAP_CONFIG_B, I_STRAP_CONFIG_A} != strap_prev_q) ?
            4'h0 : steady_q + {3'h0, steady_q != 4'hf};
         mdc_q <= I_MDC;
         cyc_q <= I_RESET_N ? cyc_q + 32'h1 : 32'h0;
         seen_q <= I_RESET_N && (seen_q || I_MDC != mdc_q);
      end
   end
   a_rst_quiet:
      assert property ($fell(I_RST) |-> !O_RESET_DONE [*8])
      else $error("reset-done too early");
   a_done_wait:
      assert property ($rose(O_RESET_DONE) |-> cyc_q > RESET_CYC)
      else $error("reset-done before wait ended");
   a_done_mdc:
      assert property ($rose(O_RESET_DONE) |-> seen_q)
      else $error("reset-done without MDC edge");
   a_speed_led:
      assert property (O_RESET_DONE && $past(O_RESET_DONE)
         && $stable(I_LINK_UP && I_SPEED_100)
         |-> O_LED_SPEED == (I_LINK_UP && I_SPEED_100))
      else $error("speed LED wrong");
   a_fdx_led:
      assert property (O_RESET_DONE && $past(O_RESET_DONE)
         && $past(I_FULL_DUPLEX && I_LINK_UP) |-> O_LED_DUPCOL)
      else $error("duplex LED off");
   a_col_blink:
      assert property ((O_RESET_DONE && !I_FULL_DUPLEX && I_COLLISION)[*8]
         |-> ##[0:8] $changed(O_LED_DUPCOL))
      else $error("collision LED not blinking");
   a_adv_on:
      assert property (O_AUTONEG_EN && $past(O_AUTONEG_EN)
         && steady_q > 4'h5
         |-> O_ADVERTISE_SEL == {I_STRAP_CONFIG_B, I_STRAP_CONFIG_A})
      else $error("advertise select wrong");
   a_adv_off:
      assert property (!O_AUTONEG_EN && !$past(O_AUTONEG_EN)
         |-> O_ADVERTISE_SEL == 2'b00)
      else $error("advertise select not cleared");
   cover property ($rose(O_RESET_DONE));
   cover property (O_AUTONEG_EN && O_ADVERTISE_SEL == 2'b01);
   cover property ($changed(O_LED_DUPCOL) && I_COLLISION);
endmodule // srlc_sva
bind srlc_top srlc_sva #(.RESET_CYC(RESET_CYC)) sva_u (.*);
`default_nettype wire

/* File: testbench/srlc_partner.sv */
/* Board straps and management controller facing srlc_top.
 Assumes the bench asks for each MDC edge and sets the pull levels. */
`timescale 1ns/1ns
`default_nettype none
module srlc_partner (
   input wire logic i_clk,
   input wire logic i_kick,
   input wire logic i_pull_dc,
   input wire logic i_pull_sp,
   input wire logic i_led_dc,
   input wire logic i_led_dc_oe,
   input wire logic i_led_sp,
   input wire logic i_led_sp_oe,
   output logic o_mdc,
   output logic o_pin_dc,
   output logic o_pin_sp
);
   // A released LED pin rests at the board's strap resistor level.
   assign o_pin_dc = i_led_dc_oe ? i_led_dc : i_pull_dc;
   assign o_pin_sp = i_led_sp_oe ? i_led_sp : i_pull_sp;
   initial o_mdc = 1'b0;
   // MDC stands still except for one edge on request.
   always @(posedge i_clk) begin
      if (i_kick) o_mdc <= !o_mdc;
   end
endmodule // srlc_partner
`default_nettype wire

/* File: testbench/tb_srlc_top.sv */
/* Bench for srlc_top: straps, reset sequence, LEDs and registers.
 Assumes short reset and blink counts set at the instance. */
`timescale 1ns/1ns
`default_nettype none
module tb_srlc_top;
   logic I_CLK_SYS = 1'b0, I_RST = 1'b1, I_RESET_N = 1'b1, kick = 1'b0;
   logic I_STRAP_CONFIG_A = 1'b1, I_STRAP_CONFIG_B = 1'b1;
   logic I_AUTONEG_STRAP = 1'b0, I_INTERFACE_SELECT_STRAP = 1'b0, lv;
   logic I_LINK_UP = 1'b0, I_SPEED_100 = 1'b0, I_FULL_DUPLEX = 1'b0;
   logic I_COLLISION = 1'b0, pull_dc = 1'b1, pull_sp = 1'b0;
   logic S_AXI_AWVALID = 1'b0, S_AXI_WVALID = 1'b0, S_AXI_BREADY = 1'b0;
   logic S_AXI_ARVALID = 1'b0, S_AXI_RREADY = 1'b0;
   logic [31:0] S_AXI_AWADDR = 32'h0, S_AXI_WDATA = 32'h0, d;
   logic [31:0] S_AXI_ARADDR = 32'h0;
   logic [3:0] S_AXI_WSTRB = 4'hf;
   logic [1:0] r;
   wire I_MDC, I_LED_DUPCOL, I_LED_SPEED, O_LED_DUPCOL, O_LED_DUPCOL_OE;
   wire O_LED_SPEED, O_LED_SPEED_OE, O_RESET_DONE, O_MLT3_BYPASS;
   wire O_LOOPBACK, O_AUTONEG_EN, O_REDUCED_IF, S_AXI_AWREADY;
   wire S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
   wire [1:0] O_ADVERTISE_SEL, S_AXI_BRESP, S_AXI_RRESP;
   wire [31:0] S_AXI_RDATA;
   int bad_count = 0, comparisons = 0, tog;
   always #5 I_CLK_SYS = ~I_CLK_SYS;
   srlc_top #(.RESET_CYC(20), .BLINK_HALF_CYC(4)) dut_u (.*);
   srlc_partner board_u (.i_clk(I_CLK_SYS), .i_kick(kick),
      .i_pull_dc(pull_dc), .i_pull_sp(pull_sp), .i_led_dc(O_LED_DUPCOL),
      .i_led_dc_oe(O_LED_DUPCOL_OE), .i_led_sp(O_LED_SPEED),
      .i_led_sp_oe(O_LED_SPEED_OE), .o_mdc(I_MDC),
      .o_pin_dc(I_LED_DUPCOL), .o_pin_sp(I_LED_SPEED));
   task automatic summarize;
      if (bad_count == 0 && comparisons > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      comparisons++;
      if (s !== e) begin
         bad_count++;
         $display("ERROR at %0t seen %h expected %h", $time, s, e);
      end
   endtask
   task automatic lim(input int n);
      if (n >= 60) begin
         bad_count++;
         summarize();
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge I_CLK_SYS);
   endtask
   task automatic wr(input logic [31:0] a, input logic [31:0] v);
      int n;
      n = 0;
      @(posedge I_CLK_SYS);
      S_AXI_AWADDR <= a;
      S_AXI_WDATA <= v;
      S_AXI_AWVALID <= 1'b1;
      S_AXI_WVALID <= 1'b1;
      S_AXI_BREADY <= 1'b1;
      do begin
         @(posedge I_CLK_SYS);
         n++;
         if (S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
         if (S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
      end while (!S_AXI_BVALID && n < 60);
      r = S_AXI_BRESP;
      S_AXI_BREADY <= 1'b0;
      lim(n);
   endtask
   task automatic rd(input logic [31:0] a);
      int n;
      n = 0;
      @(posedge I_CLK_SYS);
      S_AXI_ARADDR <= a;
      S_AXI_ARVALID <= 1'b1;
      S_AXI_RREADY <= 1'b1;
      do begin
         @(posedge I_CLK_SYS);
         n++;
         if (S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
      end while (!S_AXI_RVALID && n < 60);
      d = S_AXI_RDATA;
      r = S_AXI_RRESP;
      S_AXI_RREADY <= 1'b0;
      lim(n);
   endtask
   // Reset must stay pending past the wait until MDC moves once.
   task automatic settle;
      int n;
      n = 0;
      tick(40);
      chk(O_RESET_DONE, 0);
      kick <= 1'b1;
      tick(1);
      kick <= 1'b0;
      while (!O_RESET_DONE && n < 60) begin
         tick(1);
         n++;
      end
      lim(n);
      chk(O_RESET_DONE, 1);
   endtask
   initial begin
      tick(10);
      I_RST <= 1'b0;
      settle();
      rd(32'h08);
      chk(d & 32'h18, 32'h10);
      chk({O_LED_DUPCOL_OE, O_LED_SPEED_OE}, 2'b11);
      rd(32'h0c);
      chk({r, d[7:2]}, 8'h30);
      rd(32'h04);
      chk({d[1], O_MLT3_BYPASS}, 2'b11);
      rd(32'h00);
      chk({d[14], O_LOOPBACK, O_AUTONEG_EN}, 3'b110);
      rd(32'h10);
      chk({r, d[3:0]}, 6'h20);
      wr(32'h08, 32'h0);
      chk(r, 0);
      rd(32'h08);
      chk(d & 32'h18, 32'h10);
      wr(32'h00, 32'h1000);
      wr(32'h04, 32'h0);
      tick(2);
      chk({O_AUTONEG_EN, O_LOOPBACK, O_ADVERTISE_SEL}, 4'hb);
      chk(O_MLT3_BYPASS, 0);
      wr(32'h00, 32'h0);
      I_LINK_UP <= 1'b1;
      I_SPEED_100 <= 1'b1;
      I_FULL_DUPLEX <= 1'b1;
      tick(3);
      chk({O_LED_SPEED, O_LED_DUPCOL, O_AUTONEG_EN}, 3'b110);
      I_SPEED_100 <= 1'b0;
      I_FULL_DUPLEX <= 1'b0;
      I_COLLISION <= 1'b1;
      tick(4);
      chk(O_LED_SPEED, 0);
      tog = 0;
      lv = O_LED_DUPCOL;
      repeat (40) begin
         tick(1);
         if (O_LED_DUPCOL !== lv) tog++;
         lv = O_LED_DUPCOL;
      end
      chk(tog >= 8 && tog <= 10, 1);
      I_COLLISION <= 1'b0;
      I_STRAP_CONFIG_B <= 1'b0;
      I_AUTONEG_STRAP <= 1'b1;
      I_INTERFACE_SELECT_STRAP <= 1'b1;
      pull_dc <= 1'b0;
      pull_sp <= 1'b1;
      I_RESET_N <= 1'b0;
      tick(30);
      chk({O_RESET_DONE, O_LED_DUPCOL_OE, O_LED_SPEED_OE}, 0);
      I_RESET_N <= 1'b1;
      settle();
      rd(32'h08);
      chk(d & 32'h18, 32'h08);
      chk({O_AUTONEG_EN, O_ADVERTISE_SEL, O_REDUCED_IF}, 4'hb);
      summarize();
   end
endmodule // tb_srlc_top
`default_nettype wire
